// ===== verilog/fbpm_mapper.sv
`timescale 1ns/1ps
// Summary of operation
// - output object: analog bytes first, then digital
// - each analog output channel takes two bytes
// - four bytes per analog terminal, strip order
// - each digital byte drives eight outputs, bit order
// - surplus bits of last output byte dropped
// - input object: analog, digital, then status byte
// - four bytes per analog input terminal
// - eight digital inputs per byte, spare bits zero
// - status byte 0 without fault, 1 after error
// - node address 0..63 from decimal switches
// - bit rate detected automatically, three rates
// - poll object answered with input object
// - send input object when its content changes
// - send input object each cycle interval
// - strobe broadcast answered with input object
// - parameters only via separate explicit messages
// - only group 2 identifiers for own node, strobe with any node field
// - code 7 duplicate check, code 6 connection
// - transmit only on idle bus, arbitration restart
// - on link loss clear digital, analog to fallback
module fbpm_mapper import fbpm_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic can_rx_pin,
  input wire logic [3:0] node_tens_sw,
  input wire logic [3:0] node_ones_sw,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [ID_W-1:0] rx_id,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic bus_idle,
  input wire logic bus_fault,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [ID_W-1:0] tx_id,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_lost,
  output logic expl_frame,
  output logic conn_mgmt_frame,
  output logic dup_check_frame,
  output logic [NODE_W-1:0] node_identifier,
  output logic [1:0] baud_sel,
  output logic baud_ok,
  input wire logic cyc_en,
  input wire logic change_triggered_exchange,
  input wire logic [15:0] cyc_interval_ms,
  input wire logic [AO_CH*16-1:0] ao_fallback,
  output logic [AO_CH*16-1:0] ao_value,
  output logic [DO_N-1:0] do_bits,
  input wire logic [AI_CH*16-1:0] ai_value,
  input wire logic [DI_N-1:0] di_pins,
  input wire logic strip_fault,
  output logic io_run_led,
  output logic io_err_led,
  output logic link_ok
);

  // all state of the mapper
  typedef struct packed {
    logic can_s1; // bus level synchroniser, first stage
    logic can_s2; // bus level synchroniser, second stage
    logic can_prev; // last synchronised level
    logic [11:0] run_cnt; // length of current level run
    logic [11:0] min_run; // shortest run seen so far
    fbpm_baud_type baud; // classified bit rate
    logic baud_ok; // a rate has been recognised
    logic [7:0] sw_s1; // switch synchroniser, first stage
    logic [7:0] sw_s2; // switch synchroniser, second stage
    logic [NODE_W-1:0] node; // node address
    logic [DI_N-1:0] di_s1; // digital input synchroniser, first stage
    logic [DI_N-1:0] di_s2; // digital input synchroniser, second stage
    logic [3:0] rx_cnt; // byte index inside output object
    logic [OUT_BYTES-1:0][7:0] stage; // output object being assembled
    logic [AO_CH*16-1:0] ao; // applied analog outputs
    logic [DO_N-1:0] dout; // applied digital outputs
    logic link_ok; // exchange alive
    logic err; // sticky strip error
    logic [31:0] tick_cnt; // millisecond prescaler
    logic [15:0] wd_ms; // time since last good object
    logic [15:0] cyc_ms; // time inside cycle interval
    logic reply_pend; // poll or strobe awaiting answer
    logic cyc_pend; // cycle interval expired
    fbpm_tx_state_type tx_st; // reply sender state
    logic [3:0] tx_idx; // byte being sent
    logic [IN_BYTES-1:0][7:0] tx_img; // input object being sent
    logic [IN_BYTES-1:0][7:0] sent_img; // last input object sent
    logic tx_valid; // byte offered to controller
    logic tx_last; // offered byte ends object
    logic [7:0] tx_data; // offered byte
    logic [ID_W-1:0] tx_id; // identifier of reply
    logic expl_p; // explicit message pulse
    logic conn_p; // connection management pulse
    logic dup_p; // duplicate address check pulse
  } fbpm_map_state_type;

  fbpm_map_state_type st_r; // registered state
  fbpm_map_state_type st_nxt; // next state

  logic [1:0] id_pfx; // top identifier bits
  logic [NODE_W-1:0] id_node; // node field of identifier
  logic [2:0] id_code; // message code of identifier
  logic grp2; // identifier is group 2
  logic to_me; // node field matches own address
  logic to_fifo; // frame carries process data
  logic fifo_in_valid; // byte pushed into fifo
  logic fifo_in_ready; // fifo has room
  logic [RX_WORD_W-1:0] fifo_in_data; // {strobe, last, byte}
  logic fifo_out_valid; // fifo holds a byte
  logic fifo_out_ready; // mapper takes a byte
  logic [RX_WORD_W-1:0] fifo_out_data; // head of fifo
  logic [IN_BYTES-1:0][7:0] cur_img; // live input object
  logic [7:0] status_byte; // trailing status
  logic [7:0] node_sum; // decoded switch value
  logic tick; // one millisecond elapsed

  // identifier decode in front of the fifo
  assign id_pfx = rx_id[ID_W-1:ID_PFX_LSB];
  assign id_node = rx_id[ID_NODE_LSB +: NODE_W];
  assign id_code = rx_id[2:0];
  assign grp2 = (id_pfx == ID_GRP2_PFX);
  assign to_me = (id_node == st_r.node);
  // strobe is a broadcast, its node field names the master
  assign to_fifo = grp2 && ((id_code == CODE_POLL && to_me) || id_code == CODE_STROBE);
  assign fifo_in_valid = rx_valid && to_fifo;
  assign fifo_in_data = {id_code == CODE_STROBE, rx_last, rx_data};
  // frames for others or for other handlers are never stalled
  assign rx_ready = to_fifo ? fifo_in_ready : 1'b1;
  // drain stops while a reply is owed, so the fifo really fills
  assign fifo_out_ready = (st_r.tx_st == TX_IDLE) && !st_r.reply_pend;

  fbpm_fifo #(
    .WIDTH(RX_WORD_W),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // live input object: analog, digital packed, status last
  assign status_byte = st_r.err ? STATUS_ERR : STATUS_OK;
  assign cur_img = {status_byte, {(DI_BYTES*8-DI_N){1'b0}}, st_r.di_s2, ai_value};
  // tens times ten plus ones
  assign node_sum = 8'({4'h0, st_r.sw_s2[7:4]} * 8'h0A) + {4'h0, st_r.sw_s2[3:0]};
  assign tick = (st_r.tick_cnt == 32'(TICK_CYCLES - 1));

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.expl_p = 1'b0;
    st_nxt.conn_p = 1'b0;
    st_nxt.dup_p = 1'b0;

    // pin synchronisers
    st_nxt.can_s1 = can_rx_pin;
    st_nxt.can_s2 = st_r.can_s1;
    st_nxt.sw_s1 = {node_tens_sw, node_ones_sw};
    st_nxt.sw_s2 = st_r.sw_s1;
    st_nxt.di_s1 = di_pins;
    st_nxt.di_s2 = st_r.di_s1;

    // node address, values past the top clamp to the top
    st_nxt.node = (node_sum > {2'h0, NODE_MAX}) ? NODE_MAX : node_sum[NODE_W-1:0];

    // shortest level run gives the bit time; a glitch would spoil it, so
    // the controller's filter should sit before this pin
    st_nxt.can_prev = st_r.can_s2;
    if (st_r.can_s2 != st_r.can_prev) begin
      if (st_r.run_cnt < st_r.min_run) begin
        st_nxt.min_run = st_r.run_cnt;
      end
      st_nxt.run_cnt = 12'h001;
    end else if (st_r.run_cnt != 12'hFFF) begin
      st_nxt.run_cnt = st_r.run_cnt + 12'h001;
    end
    st_nxt.baud_ok = (st_r.min_run <= THR_125);
    if (st_r.min_run <= THR_500) begin
      st_nxt.baud = BAUD_500;
    end else if (st_r.min_run <= THR_250) begin
      st_nxt.baud = BAUD_250;
    end else begin
      st_nxt.baud = BAUD_125;
    end

    // sticky strip error
    if (strip_fault) begin
      st_nxt.err = 1'b1;
    end

    // millisecond prescaler
    st_nxt.tick_cnt = tick ? 32'h0 : st_r.tick_cnt + 32'h1;

    // group 2 codes 4, 6 and 7 for this node are flagged to their own handlers
    if (rx_valid && rx_last && grp2 && to_me) begin
      st_nxt.expl_p = (id_code == CODE_EXPL);
      st_nxt.conn_p = (id_code == CODE_CONN);
      st_nxt.dup_p = (id_code == CODE_DUP);
    end

    // watchdog and external fault drop the link
    if (tick && st_r.link_ok) begin
      if (st_r.wd_ms >= WDOG_MS - 16'h1) begin
        st_nxt.link_ok = 1'b0;
      end else begin
        st_nxt.wd_ms = st_r.wd_ms + 16'h1;
      end
    end
    if (bus_fault) begin
      st_nxt.link_ok = 1'b0;
    end

    // cycle interval
    if (!cyc_en) begin
      st_nxt.cyc_ms = 16'h0;
    end else if (tick) begin
      if (st_r.cyc_ms >= cyc_interval_ms - 16'h1 || cyc_interval_ms == 16'h0) begin
        st_nxt.cyc_ms = 16'h0;
      end else begin
        st_nxt.cyc_ms = st_r.cyc_ms + 16'h1;
      end
    end

    // reply sender
    unique case (st_r.tx_st)
      TX_IDLE: begin
        if (st_r.reply_pend || st_r.cyc_pend
            || (change_triggered_exchange && cur_img != st_r.sent_img)) begin
          st_nxt.tx_img = cur_img;
          st_nxt.sent_img = cur_img;
          st_nxt.reply_pend = 1'b0;
          st_nxt.cyc_pend = 1'b0;
          st_nxt.tx_st = TX_WAIT;
        end
      end
      TX_WAIT: begin
        // only start on a free bus
        if (bus_idle) begin
          st_nxt.tx_idx = 4'h0;
          st_nxt.tx_data = st_r.tx_img[0];
          st_nxt.tx_last = (IN_BYTES == 1);
          st_nxt.tx_id = {ID_GRP2_PFX, st_r.node, CODE_TX};
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_st = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_lost) begin
          // lost arbitration: withdraw and offer the object again
          st_nxt.tx_valid = 1'b0;
          st_nxt.tx_st = TX_WAIT;
        end else if (tx_ready) begin
          if (st_r.tx_last) begin
            st_nxt.tx_valid = 1'b0;
            st_nxt.tx_last = 1'b0;
            st_nxt.tx_st = TX_IDLE;
          end else begin
            st_nxt.tx_idx = st_r.tx_idx + 4'h1;
            st_nxt.tx_data = st_r.tx_img[st_r.tx_idx + 4'h1];
            st_nxt.tx_last = (st_r.tx_idx + 4'h1 == 4'(IN_BYTES - 1));
          end
        end
      end
      default: begin
        st_nxt.tx_valid = 1'b0;
        st_nxt.tx_st = TX_IDLE;
      end
    endcase

    // new requests set after the clears above, so none is lost
    if (cyc_en && tick && (st_r.cyc_ms >= cyc_interval_ms - 16'h1 || cyc_interval_ms == 16'h0)) begin
      st_nxt.cyc_pend = 1'b1;
    end

    // process data from the fifo
    if (fifo_out_valid && fifo_out_ready) begin
      if (fifo_out_data[9]) begin
        if (fifo_out_data[8]) begin
          st_nxt.reply_pend = 1'b1;
        end
      end else begin
        // bytes collected in arrival order: analog first, then digital
        if (st_r.rx_cnt < 4'(OUT_BYTES)) begin
          st_nxt.stage[st_r.rx_cnt] = fifo_out_data[7:0];
        end
        if (st_r.rx_cnt != 4'hF) begin
          st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
        end
        if (fifo_out_data[8]) begin
          st_nxt.rx_cnt = 4'h0;
          st_nxt.reply_pend = 1'b1;
          // a wrong length object is answered but not applied
          if (st_r.rx_cnt == 4'(OUT_BYTES - 1)) begin
            // whole object in hand: update every output at once
            st_nxt.ao = st_nxt.stage[AO_BYTES-1:0];
            st_nxt.dout = DO_N'(st_nxt.stage[OUT_BYTES-1:AO_BYTES]);
            st_nxt.link_ok = 1'b1;
            st_nxt.wd_ms = 16'h0;
          end
        end
      end
    end

    // safe outputs while the link is down; counters elsewhere are untouched
    if (!st_nxt.link_ok) begin
      st_nxt.ao = ao_fallback;
      st_nxt.dout = '0;
    end
  end

  // register the state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.can_s1 <= 1'b1;
      st_r.can_s2 <= 1'b1;
      st_r.can_prev <= 1'b1;
      st_r.min_run <= MIN_RUN_INIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state
  assign tx_valid = st_r.tx_valid;
  assign tx_id = st_r.tx_id;
  assign tx_data = st_r.tx_data;
  assign tx_last = st_r.tx_last;
  assign expl_frame = st_r.expl_p;
  assign conn_mgmt_frame = st_r.conn_p;
  assign dup_check_frame = st_r.dup_p;
  assign node_identifier = st_r.node;
  assign baud_sel = st_r.baud;
  assign baud_ok = st_r.baud_ok;
  assign ao_value = st_r.ao;
  assign do_bits = st_r.dout;
  assign io_run_led = !st_r.err;
  assign io_err_led = st_r.err;
  assign link_ok = st_r.link_ok;

endmodule : fbpm_mapper

// ===== verilog/fbpm_pkg.sv
// shared constants of the process image mapper
package fbpm_pkg;

  // terminal strip make-up; every analog terminal has two 16-bit channels
  localparam int AO_TERMS = 2;
  localparam int AO_CH = AO_TERMS * 2;
  localparam int AO_BYTES = AO_TERMS * 4;
  localparam int DO_N = 10;
  localparam int DO_BYTES = (DO_N + 7) / 8;
  localparam int OUT_BYTES = AO_BYTES + DO_BYTES;
  localparam int AI_TERMS = 2;
  localparam int AI_CH = AI_TERMS * 2;
  localparam int AI_BYTES = AI_TERMS * 4;
  localparam int DI_N = 12;
  localparam int DI_BYTES = (DI_N + 7) / 8;
  localparam int IN_BYTES = AI_BYTES + DI_BYTES + 1;

  // 11-bit identifier layout
  localparam int ID_W = 11;
  localparam int ID_PFX_LSB = 9;
  localparam int ID_NODE_LSB = 3;
  localparam int NODE_W = 6;
  localparam logic [1:0] ID_GRP2_PFX = 2'h2;
  localparam logic [2:0] CODE_STROBE = 3'h0;
  localparam logic [2:0] CODE_TX = 3'h3;
  localparam logic [2:0] CODE_EXPL = 3'h4;
  localparam logic [2:0] CODE_POLL = 3'h5;
  localparam logic [2:0] CODE_CONN = 3'h6;
  localparam logic [2:0] CODE_DUP = 3'h7;
  localparam logic [5:0] NODE_MAX = 6'h3F;

  // status byte values
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_ERR = 8'h01;

  // timing
  localparam int CLK_NS = 8;
  localparam int BIT_NS_125 = 8000;
  localparam int BIT_NS_250 = 4000;
  localparam int BIT_NS_500 = 2000;
  localparam int BIT_CYC_125 = BIT_NS_125 / CLK_NS;
  localparam int BIT_CYC_250 = BIT_NS_250 / CLK_NS;
  localparam int BIT_CYC_500 = BIT_NS_500 / CLK_NS;
  localparam logic [11:0] THR_500 = 12'((BIT_CYC_500 + BIT_CYC_250) / 2);
  localparam logic [11:0] THR_250 = 12'((BIT_CYC_250 + BIT_CYC_125) / 2);
  localparam logic [11:0] THR_125 = 12'(BIT_CYC_125 + BIT_CYC_125 / 2);
  localparam logic [11:0] MIN_RUN_INIT = 12'hFFF;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  localparam logic [15:0] WDOG_MS = 16'h0064;

  // receive fifo
  localparam int RX_WORD_W = 10;
  localparam int RX_FIFO_DEPTH = 16;

  // detected bit rate
  typedef enum logic [1:0] {
    BAUD_125 = 2'b00,
    BAUD_250 = 2'b01,
    BAUD_500 = 2'b10
  } fbpm_baud_type;

  // reply sender states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_SEND = 2'b10
  } fbpm_tx_state_type;

endpackage : fbpm_pkg

// ===== verilog/fbpm_fifo.sv
`timescale 1ns/1ps
// synchronous fifo, depth must be a power of two
module fbpm_fifo import fbpm_pkg::*; #(
  parameter int unsigned WIDTH = RX_WORD_W,
  parameter int unsigned DEPTH = RX_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  // storage plus pointers with one wrap bit each
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fbpm_fifo_state_type;

  fbpm_fifo_state_type st_r; // registered state
  fbpm_fifo_state_type st_nxt; // next state
  logic full; // wrap bits differ, indices equal
  logic empty; // pointers equal

  assign full = (st_r.wr[AW] != st_r.rd[AW]) && (st_r.wr[AW-1:0] == st_r.rd[AW-1:0]);
  assign empty = (st_r.wr == st_r.rd);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st_r.mem[st_r.rd[AW-1:0]];

  // push and pop may happen in the same cycle
  always_comb begin
    st_nxt = st_r;
    if (in_valid && !full) begin
      st_nxt.mem[st_r.wr[AW-1:0]] = in_data;
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
  end

  // register the state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : fbpm_fifo

// ===== verification/fbpm_monitor.sv
`timescale 1ns/1ps
// watches the mapper's ports for slips in framing, replies and fail-safe
module fbpm_monitor import fbpm_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] node_tens_sw,
  input wire logic [3:0] node_ones_sw,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [ID_W-1:0] rx_id,
  input wire logic rx_last,
  input wire logic bus_idle,
  input wire logic bus_fault,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [ID_W-1:0] tx_id,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_lost,
  input wire logic expl_frame,
  input wire logic conn_mgmt_frame,
  input wire logic dup_check_frame,
  input wire logic [NODE_W-1:0] node_identifier,
  input wire logic [AO_CH*16-1:0] ao_fallback,
  input wire logic [AO_CH*16-1:0] ao_value,
  input wire logic [DO_N-1:0] do_bits,
  input wire logic io_run_led,
  input wire logic io_err_led,
  input wire logic link_ok
);
  logic [7:0] node_sum; // switch value before clamping
  assign node_sum = 8'(node_tens_sw) * 8'h0A + 8'(node_ones_sw);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // last byte of a frame to this node carrying the given code
  sequence frame_end(code);
    rx_valid && rx_ready && rx_last && rx_id == {ID_GRP2_PFX, node_identifier, code};
  endsequence
  // switches settled out of reset, past the synchronisers
  sequence sw_held;
    (rst_b && $stable(node_tens_sw) && $stable(node_ones_sw)) [*4];
  endsequence
  // link down for two samples, so the fail-safe has had its cycle
  sequence link_down;
    !link_ok [*2];
  endsequence
  node_map_a: assert property (sw_held |-> node_identifier == ((node_sum > 8'h3F) ? NODE_MAX : node_sum[5:0]))
    else $error("node address differs from switches");
  expl_flag_a: assert property (frame_end(CODE_EXPL) |=> expl_frame)
    else $error("explicit frame not flagged");
  conn_flag_a: assert property (frame_end(CODE_CONN) |=> conn_mgmt_frame)
    else $error("connection frame not flagged");
  dup_flag_a: assert property (frame_end(CODE_DUP) |=> dup_check_frame)
    else $error("duplicate check not flagged");
  tx_ident_a: assert property (tx_valid |-> tx_id == {ID_GRP2_PFX, node_identifier, CODE_TX})
    else $error("reply identifier wrong");
  tx_hold_a: assert property (tx_valid && !tx_ready && !tx_lost |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("reply byte changed while stalled");
  idle_start_a: assert property ($rose(tx_valid) |-> $past(bus_idle))
    else $error("reply started on busy bus");
  lost_drop_a: assert property (tx_valid && tx_lost |=> !tx_valid)
    else $error("reply kept after lost arbitration");
  status_a: assert property (tx_valid && tx_last |-> tx_data == STATUS_OK || (tx_data == STATUS_ERR && io_err_led))
    else $error("status byte wrong");
  led_pair_a: assert property (io_run_led != io_err_led)
    else $error("run and error lamps agree");
  fail_safe_a: assert property (link_down |-> do_bits == '0 && ao_value == ao_fallback)
    else $error("outputs not safe while link down");
  fault_drop_a: assert property (bus_fault |-> ##[1:2] !link_ok)
    else $error("link kept after bus fault");
endmodule : fbpm_monitor

// ===== verification/fbpm_scanner.sv
`timescale 1ns/1ps
// behavioural scanner: sends objects, takes replies, can stall or lose once
module fbpm_scanner import fbpm_pkg::*; (
  input wire logic clk,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [ID_W-1:0] rx_id,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic bus_idle,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_lost
);
  logic [7:0] obj [16]; // bytes of the next object, analog first
  logic [7:0] got [$]; // reply bytes as taken
  int n_obj; // replies completed
  logic slow; // take a reply byte only every other cycle
  logic lose_once; // lose arbitration once in the next reply
  initial begin
    rx_valid = 1'b0;
    rx_id = '0;
    rx_data = '0;
    rx_last = 1'b0;
    bus_idle = 1'b1;
    tx_ready = 1'b1;
    tx_lost = 1'b0;
    n_obj = 0;
    slow = 1'b0;
    lose_once = 1'b0;
  end
  // reply side; ready drops while losing, so no byte is both taken and lost
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      if (tx_last) n_obj++;
    end
    #1;
    tx_lost = lose_once && tx_valid && got.size() == 3;
    if (tx_lost) begin
      lose_once = 1'b0;
      got.delete();
    end
    tx_ready = !tx_lost && (!slow || !tx_ready);
  end
  // one frame; the bus counts as busy for its whole length
  task automatic send(input logic [ID_W-1:0] id, input int n);
    @(posedge clk);
    #1;
    bus_idle = 1'b0;
    rx_id = id;
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_data = obj[i];
      rx_last = (i == n - 1);
      @(posedge clk);
      while (!rx_ready) @(posedge clk);
      #1;
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data; // released lines carry no stale byte
    rx_id = ~rx_id;
    bus_idle = 1'b1;
  endtask : send
endmodule : fbpm_scanner

// ===== verification/tb_fieldbus_process_image_mapper.sv
`timescale 1ns/1ps
module tb_fieldbus_process_image_mapper import fbpm_pkg::*;;
  logic clk, rst_b, can_rx_pin, bus_fault, cyc_en, change_triggered_exchange, strip_fault;
  logic [3:0] node_tens_sw, node_ones_sw;
  logic rx_valid, rx_ready, rx_last, bus_idle, tx_valid, tx_ready, tx_last, tx_lost;
  logic [ID_W-1:0] rx_id, tx_id;
  logic [7:0] rx_data, tx_data;
  logic expl_frame, conn_mgmt_frame, dup_check_frame, baud_ok, io_run_led, io_err_led, link_ok;
  logic [NODE_W-1:0] node_identifier;
  logic [1:0] baud_sel;
  logic [15:0] cyc_interval_ms;
  logic [AO_CH*16-1:0] ao_fallback, ao_value;
  logic [DO_N-1:0] do_bits;
  logic [AI_CH*16-1:0] ai_value;
  logic [DI_N-1:0] di_pins;
  int err_count, num_checks;
  // tick shortened so watchdog and cycle timer fit a short run
  fbpm_mapper #(.TICK_CYCLES(10)) u_dut (.clk, .rst_b, .can_rx_pin, .node_tens_sw, .node_ones_sw,
    .rx_valid, .rx_ready, .rx_id, .rx_data, .rx_last, .bus_idle, .bus_fault, .tx_valid, .tx_ready,
    .tx_id, .tx_data, .tx_last, .tx_lost, .expl_frame, .conn_mgmt_frame, .dup_check_frame,
    .node_identifier, .baud_sel, .baud_ok, .cyc_en, .change_triggered_exchange, .cyc_interval_ms,
    .ao_fallback, .ao_value, .do_bits, .ai_value, .di_pins, .strip_fault, .io_run_led, .io_err_led, .link_ok);
  fbpm_scanner u_scn (.clk, .rx_valid, .rx_ready, .rx_id, .rx_data, .rx_last, .bus_idle,
    .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_lost);
  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, seen, exp);
    end
  endtask : chk
  task conclude;
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // bounded wait for the scanner to count n replies
  task wait_obj(input int n);
    for (int k = 0; k < 3000 && u_scn.n_obj < n; k++) @(posedge clk);
    #1;
    chk(u_scn.n_obj >= n, 1, "reply missing");
  endtask : wait_obj
  // compare the reply taken with the image built here
  task chk_reply(input logic [7:0] st);
    logic [7:0] e [11];
    for (int k = 0; k < 8; k++) e[k] = ai_value[8*k+:8];
    e[8] = di_pins[7:0];
    e[9] = {4'h0, di_pins[11:8]}; // spare bits empty
    e[10] = st;
    chk(u_scn.got.size(), 11, "reply length");
    for (int k = 0; k < 11 && k < u_scn.got.size(); k++) chk(u_scn.got[k], e[k], "reply byte");
    u_scn.got.delete();
  endtask : chk_reply
  // poll with a full object, then check outputs and answer
  task do_poll(input logic [7:0] base, input logic [7:0] st);
    int n0;
    logic [63:0] ea;
    n0 = u_scn.n_obj;
    for (int i = 0; i < 16; i++) u_scn.obj[i] = 8'(base + i * 17);
    for (int i = 0; i < 8; i++) ea[8*i+:8] = u_scn.obj[i];
    u_scn.got.delete();
    u_scn.send({ID_GRP2_PFX, 6'h2A, CODE_POLL}, OUT_BYTES);
    wait_obj(n0 + 1);
    chk(ao_value, ea, "analog outputs");
    chk(do_bits, {u_scn.obj[9][1:0], u_scn.obj[8]}, "digital outputs");
    chk(link_ok, 1, "link up");
    chk_reply(st);
  endtask : do_poll
  // other node, other group, short object, codes 4, 6 and 7
  task t_ignore;
    int n0;
    logic [63:0] a0;
    n0 = u_scn.n_obj;
    a0 = ao_value;
    for (int i = 0; i < 16; i++) u_scn.obj[i] = 8'(8'h40 + i);
    u_scn.send({ID_GRP2_PFX, 6'h2B, CODE_POLL}, OUT_BYTES);
    u_scn.send({2'h3, 6'h2A, CODE_POLL}, OUT_BYTES);
    u_scn.send({ID_GRP2_PFX, 6'h2A, CODE_POLL}, 5); // answered but not applied
    for (int c = 4; c < 8; c++) if (c != 5) u_scn.send({ID_GRP2_PFX, 6'h2A, 3'(c)}, 1);
    tick(60);
    chk(u_scn.n_obj, n0 + 1, "replies to foreign frames");
    chk(ao_value, a0, "outputs after foreign frames");
    u_scn.got.delete();
  endtask : t_ignore
  // strobe to any node, answered under a stalling scanner
  task t_strobe;
    int n0;
    n0 = u_scn.n_obj;
    u_scn.slow = 1'b1;
    u_scn.send({ID_GRP2_PFX, 6'h05, CODE_STROBE}, 1);
    wait_obj(n0 + 1);
    chk_reply(STATUS_OK);
    u_scn.slow = 1'b0;
  endtask : t_strobe
  task t_lost;
    u_scn.lose_once = 1'b1;
    do_poll(8'h21, STATUS_OK);
    chk(u_scn.lose_once, 0, "arbitration loss not exercised");
  endtask : t_lost
  task t_change;
    int n0;
    change_triggered_exchange = 1'b1;
    tick(100);
    u_scn.got.delete();
    n0 = u_scn.n_obj;
    di_pins = 12'h3C6;
    wait_obj(n0 + 1);
    tick(40);
    chk(u_scn.n_obj, n0 + 1, "change sends");
    chk_reply(STATUS_OK);
    change_triggered_exchange = 1'b0;
  endtask : t_change
  // 4 ticks of 10 cycles: ten sends in 400 cycles
  task t_cyclic;
    int n0;
    cyc_en = 1'b1;
    tick(60);
    n0 = u_scn.n_obj;
    tick(400);
    cyc_en = 1'b0;
    chk(u_scn.n_obj - n0 >= 9 && u_scn.n_obj - n0 <= 11, 1, "cyclic count");
    tick(60);
  endtask : t_cyclic
  task t_fault;
    strip_fault = 1'b1;
    tick(5);
    chk(io_err_led, 1, "error lamp");
    do_poll(8'h57, STATUS_ERR);
    strip_fault = 1'b0;
    bus_fault = 1'b1;
    tick(3);
    chk({link_ok, do_bits}, '0, "fail-safe digital");
    chk(ao_value, ao_fallback, "fail-safe analog");
    bus_fault = 1'b0;
  endtask : t_fault
  // runs of 1000, 500, 250 cycles: 125k, 250k, 500k
  task t_baud;
    for (int r = 0; r < 3; r++) begin
      repeat (4) begin
        tick(1000 >> r);
        can_rx_pin = ~can_rx_pin;
      end
      tick(3);
      chk({baud_ok, baud_sel}, {1'b1, 2'(r)}, "bit rate");
    end
  endtask : t_baud
  task t_node;
    node_tens_sw = 4'h9;
    node_ones_sw = 4'h9;
    tick(6);
    chk(node_identifier, 6'h3F, "node clamp");
    node_tens_sw = 4'h1;
    node_ones_sw = 4'h7;
    tick(6);
    chk(node_identifier, 6'h11, "node decimal");
  endtask : t_node
  initial begin
    rst_b = 1'b0;
    can_rx_pin = 1'b1;
    node_tens_sw = 4'h4;
    node_ones_sw = 4'h2;
    bus_fault = 1'b0;
    cyc_en = 1'b0;
    change_triggered_exchange = 1'b0;
    cyc_interval_ms = 16'h0004;
    strip_fault = 1'b0;
    ao_fallback = 64'h0123_4567_89AB_CDEF;
    ai_value = 64'hFEDC_BA98_7654_3210;
    di_pins = 12'hA5C;
    err_count = 0;
    num_checks = 0;
    tick(16);
    rst_b = 1'b1;
    tick(4);
    do_poll(8'h03, STATUS_OK);
    t_ignore;
    t_strobe;
    t_lost;
    t_change;
    t_cyclic;
    t_fault;
    t_baud;
    t_node;
    conclude;
  end
  // hang guard, far past the 8000 or so cycles the tests take
  initial begin
    #480000;
    err_count++;
    conclude;
  end
endmodule : tb_fieldbus_process_image_mapper
bind fbpm_mapper fbpm_monitor u_mon (.clk, .rst_b, .node_tens_sw, .node_ones_sw, .rx_valid, .rx_ready,
  .rx_id, .rx_last, .bus_idle, .bus_fault, .tx_valid, .tx_ready, .tx_id, .tx_data, .tx_last, .tx_lost,
  .expl_frame, .conn_mgmt_frame, .dup_check_frame, .node_identifier, .ao_fallback, .ao_value, .do_bits,
  .io_run_led, .io_err_led, .link_ok);
